// ==== core/dcsu_map.vh ====
// bit positions, reset values and timing constants of the upper control_status bits
`ifndef DCSU_MAP_VH
`define DCSU_MAP_VH
`define DCSU_BIT_IE      6
`define DCSU_BIT_READY   7
`define DCSU_BIT_CYCLE   8
`define DCSU_BIT_STAT_A  9
`define DCSU_BIT_STAT_B  10
`define DCSU_BIT_STAT_C  11
`define DCSU_BIT_MAINTENANCE_BIT   12
`define DCSU_BIT_ATTENTION_INPUT    13
`define DCSU_BIT_NEX     14
`define DCSU_BIT_ERROR   15
`define DCSU_TIMEOUT_NS  15000
`define DCSU_CLK_NS      10
`define DCSU_SYNC_RESET  2'h0
`define DCSU_RST_IE      1'b0
`define DCSU_RST_READY   1'b1
`define DCSU_RST_CYCLE   1'b0
`define DCSU_RST_MAINTENANCE_BIT   1'b0
`define DCSU_RST_NEX     1'b0
`define DCSU_RST_ERROR   1'b0
`define DCSU_RST_IMAGE   16'h0000
`endif

// ==== core/dcsu_sync.v ====
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
`include "dcsu_map.vh"
module dcsu_sync #(
    parameter W = 5
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg [1:0] s_r;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s_r <= `DCSU_SYNC_RESET;
                end else begin
                    s_r <= {s_r[0], d[i]};
                end
            end
            assign q[i] = s_r[1];
        end
    endgenerate
endmodule // dcsu_sync

// ==== core/dcsu_top.v ====
// upper half of the DMA control_status register with ready, nex and error logic
`include "dcsu_map.vh"
`timescale 1ns/1ns
module dcsu_top #(
    parameter TIMEOUT_CYC = `DCSU_TIMEOUT_NS / `DCSU_CLK_NS
) (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST_N,
    // bus initialize, synchronous pulse from bus logic
    input  wire        BUS_INIT,
    // register access: word write with high byte strobe, read data
    input  wire        CSR_WR_HI,
    input  wire [15:0] CSR_WDATA,
    input  wire        GO_WRITE,
    input  wire        IE_WR,
    input  wire        IE_WDATA,
    output reg  [15:0] CSR_RDATA,
    // sequencer links
    input  wire        DMA_CYCLE_ACTIVE,
    input  wire        DMA_CYCLE_END,
    input  wire        WORD_COUNT_OVERFLOW,
    input  wire        REPLY_WAIT,
    input  wire        DATIO_FAIL,
    // user device pins
    input  wire        CYCLE_REQUEST,
    input  wire        USER_STATUS_INPUT_A,
    input  wire        USER_STATUS_INPUT_B,
    input  wire        USER_STATUS_INPUT_C,
    input  wire        ATTENTION_INPUT,
    // outputs
    output reg         READY,
    output reg         ERROR,
    output reg         IRQ
);
    localparam CW = 16;

    wire [4:0] pins_s;
    dcsu_sync #(.W(5)) u_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     ({ATTENTION_INPUT, USER_STATUS_INPUT_C, USER_STATUS_INPUT_B,
                 USER_STATUS_INPUT_A, CYCLE_REQUEST}),
        .q     (pins_s)
    );
    wire       cyc_req_s = pins_s[0];
    wire [2:0] stat_s    = pins_s[3:1];
    wire       attention_input_s    = pins_s[4];

    reg          ie_r;
    reg          ready_r;
    reg          cycle_r;
    reg          maintenance_bit_r;
    reg          nex_r;
    reg          ovf_pend_r;
    reg [CW-1:0] tmo_r;
    reg          err_prev_r;
    reg          ready_prev_r;

    // next values, worked out in one place so each register below stays trivial
    reg          ie_nxt;
    reg          ready_nxt;
    reg          cycle_nxt;
    reg          maintenance_bit_nxt;
    reg          nex_nxt;
    reg          ovf_pend_nxt;
    reg          err_prev_nxt;
    reg          ready_prev_nxt;
    reg [CW-1:0] image_nxt;
    reg          irq_nxt;

    wire tmo_hit = REPLY_WAIT && (tmo_r == TIMEOUT_CYC[CW-1:0] - 16'h0001);
    wire nex_set = tmo_hit || DATIO_FAIL;
    // error combines the current causes; no latch, so it drops with them
    wire err_now = nex_r || attention_input_s;

    // reply timeout counter
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            tmo_r <= 16'h0000;
        end else if (!REPLY_WAIT || tmo_hit) begin
            tmo_r <= 16'h0000;
        end else begin
            tmo_r <= tmo_r + 16'h0001;
        end
    end

    always @* begin
        ie_nxt         = ie_r;
        ready_nxt      = ready_r;
        cycle_nxt      = cycle_r;
        maintenance_bit_nxt      = maintenance_bit_r;
        nex_nxt        = nex_r;
        ovf_pend_nxt   = ovf_pend_r;
        err_prev_nxt   = err_now;
        ready_prev_nxt = ready_r;
        if (BUS_INIT) begin
            ie_nxt         = `DCSU_RST_IE;
            ready_nxt      = `DCSU_RST_READY;
            cycle_nxt      = `DCSU_RST_CYCLE;
            maintenance_bit_nxt      = `DCSU_RST_MAINTENANCE_BIT;
            nex_nxt        = `DCSU_RST_NEX;
            ovf_pend_nxt   = 1'b0;
            err_prev_nxt   = `DCSU_RST_ERROR;
            ready_prev_nxt = `DCSU_RST_READY;
        end else begin
            if (IE_WR) begin
                ie_nxt = IE_WDATA;
            end
            // overflow held until the cycle finishes
            if (WORD_COUNT_OVERFLOW && !DMA_CYCLE_END) begin
                ovf_pend_nxt = 1'b1;
            end else if (DMA_CYCLE_END) begin
                ovf_pend_nxt = 1'b0;
            end
            // set sources win over go
            if ((DMA_CYCLE_END && (ovf_pend_r || WORD_COUNT_OVERFLOW)) || err_now) begin
                ready_nxt = 1'b1;
            end else if (GO_WRITE) begin
                ready_nxt = 1'b0;
            end
            if (DMA_CYCLE_ACTIVE) begin
                cycle_nxt = 1'b0;
            end else if (cyc_req_s) begin
                cycle_nxt = 1'b1;
            end else if (CSR_WR_HI) begin
                cycle_nxt = CSR_WDATA[`DCSU_BIT_CYCLE];
            end
            if (CSR_WR_HI) begin
                maintenance_bit_nxt = CSR_WDATA[`DCSU_BIT_MAINTENANCE_BIT];
            end
            // a new fault wins over a clearing write; writing one does nothing
            if (nex_set) begin
                nex_nxt = 1'b1;
            end else if (CSR_WR_HI && !CSR_WDATA[`DCSU_BIT_NEX]) begin
                nex_nxt = 1'b0;
            end
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ie_r <= `DCSU_RST_IE;
        end else begin
            ie_r <= ie_nxt;
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ready_r <= `DCSU_RST_READY;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cycle_r <= `DCSU_RST_CYCLE;
        end else begin
            cycle_r <= cycle_nxt;
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            maintenance_bit_r <= `DCSU_RST_MAINTENANCE_BIT;
        end else begin
            maintenance_bit_r <= maintenance_bit_nxt;
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            nex_r <= `DCSU_RST_NEX;
        end else begin
            nex_r <= nex_nxt;
        end
    end

    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ovf_pend_r <= 1'b0;
        end else begin
            ovf_pend_r <= ovf_pend_nxt;
        end
    end

    // edge history for the interrupt request; init also resets it
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            err_prev_r   <= `DCSU_RST_ERROR;
            ready_prev_r <= `DCSU_RST_READY;
        end else begin
            err_prev_r   <= err_prev_nxt;
            ready_prev_r <= ready_prev_nxt;
        end
    end

    // read image; read-only bits come only from hardware sources
    always @* begin
        image_nxt                    = `DCSU_RST_IMAGE;
        image_nxt[`DCSU_BIT_IE]      = ie_r;
        image_nxt[`DCSU_BIT_READY]   = ready_r;
        image_nxt[`DCSU_BIT_CYCLE]   = cycle_r;
        image_nxt[`DCSU_BIT_STAT_A]  = stat_s[0];
        image_nxt[`DCSU_BIT_STAT_B]  = stat_s[1];
        image_nxt[`DCSU_BIT_STAT_C]  = stat_s[2];
        image_nxt[`DCSU_BIT_MAINTENANCE_BIT]   = maintenance_bit_r;
        image_nxt[`DCSU_BIT_ATTENTION_INPUT]    = attention_input_s;
        image_nxt[`DCSU_BIT_NEX]     = nex_r;
        image_nxt[`DCSU_BIT_ERROR]   = err_now;
        // request on a rising ready or rising error while enabled
        irq_nxt = ie_r && !BUS_INIT &&
                  ((ready_r && !ready_prev_r) || (err_now && !err_prev_r));
    end

    // registered outputs
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            CSR_RDATA <= `DCSU_RST_IMAGE;
            READY     <= `DCSU_RST_READY;
            ERROR     <= `DCSU_RST_ERROR;
            IRQ       <= 1'b0;
        end else begin
            CSR_RDATA <= image_nxt;
            READY     <= ready_r;
            ERROR     <= err_now;
            IRQ       <= irq_nxt;
        end
    end
endmodule // dcsu_top

// ==== verification/dcsu_asserts.sv ====
// port checks for the upper control_status bits
`timescale 1ns/1ns
module dcsu_asserts (
    input wire        CLOCK, RST_N, BUS_INIT, GO_WRITE, WORD_COUNT_OVERFLOW, DMA_CYCLE_END, DMA_CYCLE_ACTIVE,
    input wire        CYCLE_REQUEST, USER_STATUS_INPUT_A, USER_STATUS_INPUT_B, USER_STATUS_INPUT_C, ATTENTION_INPUT,
    input wire [15:0] CSR_RDATA,
    input wire        READY, ERROR, IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    wire [3:0]  pv = {ATTENTION_INPUT, USER_STATUS_INPUT_C, USER_STATUS_INPUT_B, USER_STATUS_INPUT_A};
    wire [15:0] d  = CSR_RDATA;
    property p_init; BUS_INIT |-> ##[1:2] (READY && !d[14] && !d[6]); endproperty
    a_init: assert property (p_init) else $error("init");
    property p_go; GO_WRITE && !BUS_INIT && !WORD_COUNT_OVERFLOW && d[15:13] == 0 |-> ##[1:2] !READY; endproperty
    a_go: assert property (p_go) else $error("go");
    property p_ovf; WORD_COUNT_OVERFLOW && DMA_CYCLE_END |-> ##[1:2] READY; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow");
    // pins pass two sync stages, so only settled levels are compared
    property p_pins; $stable(pv) [*6] |-> {d[13], d[11:9]} == pv; endproperty
    a_pins: assert property (p_pins) else $error("pins");
    property p_err; d[15] == (d[14] | d[13]); endproperty
    a_err: assert property (p_err) else $error("error cause");
    property p_errpin; ERROR == d[15]; endproperty
    a_errpin: assert property (p_errpin) else $error("error pin");
    property p_eready; $rose(ERROR) |-> ##[0:2] READY; endproperty
    a_eready: assert property (p_eready) else $error("error ready");
    property p_irq; IRQ |-> ##[0:1] d[6]; endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_cycle; DMA_CYCLE_ACTIVE && !CYCLE_REQUEST |-> ##[1:3] !d[8]; endproperty
    a_cycle: assert property (p_cycle) else $error("cycle");
endmodule // dcsu_asserts
bind dcsu_top dcsu_asserts u_chk (.*);

// ==== verification/dcsu_user_dev.sv ====
// user device model for status, attention and cycle request pins
`timescale 1ns/1ns
module dcsu_user_dev (
    input  wire       clk,
    input  wire [4:0] pins,
    output reg  [4:0] drv
);
    initial drv = 5'h00;
    // attention stays up until the bench drops it
    always @(posedge clk) drv <= #1 pins;
endmodule // dcsu_user_dev

// ==== verification/tb_top.sv ====
// self-checking bench for the upper control_status bits
`timescale 1ns/1ns
module tb_top;
    logic        CLOCK = 0, RST_N = 0, REPLY_WAIT = 0;
    logic [7:0]  ctl = 0;
    logic [4:0]  pins = 0;
    logic [15:0] CSR_WDATA = 0;
    wire  [4:0]  dv;
    wire         BUS_INIT = ctl[7], CSR_WR_HI = ctl[6], GO_WRITE = ctl[5], IE_WR = ctl[4], IE_WDATA = 1'b1;
    wire         DMA_CYCLE_ACTIVE = ctl[3], DMA_CYCLE_END = ctl[2], WORD_COUNT_OVERFLOW = ctl[1], DATIO_FAIL = ctl[0];
    wire         ATTENTION_INPUT = dv[4], USER_STATUS_INPUT_C = dv[3], USER_STATUS_INPUT_B = dv[2];
    wire         USER_STATUS_INPUT_A = dv[1], CYCLE_REQUEST = dv[0];
    wire  [15:0] CSR_RDATA;
    wire         READY, ERROR, IRQ;
    int          failures = 0, checks_done = 0, i;
    // ctl, write high byte, pins, then expected ready, error, image
    logic [38:0] rows [14] = '{
        {8'h40, 8'hff, 5'h00, 18'h21180}, {8'h08, 8'h00, 5'h00, 18'h21080}, {8'h00, 8'h00, 5'h01, 18'h21180},
        {8'h20, 8'h00, 5'h00, 18'h01100}, {8'h00, 8'h00, 5'h0a, 18'h01b00}, {8'h00, 8'h00, 5'h04, 18'h01500},
        {8'h00, 8'h00, 5'h10, 18'h3b180}, {8'h00, 8'h00, 5'h00, 18'h21180}, {8'h30, 8'h00, 5'h00, 18'h01140},
        {8'h40, 8'h00, 5'h00, 18'h00040}, {8'h01, 8'h00, 5'h00, 18'h3c0c0}, {8'h80, 8'h00, 5'h00, 18'h20080},
        {8'h20, 8'h00, 5'h00, 18'h00000}, {8'h16, 8'h00, 5'h00, 18'h200c0}};
    dcsu_top #(.TIMEOUT_CYC(20)) uut (.*);
    dcsu_user_dev dev (.clk(CLOCK), .pins(pins), .drv(dv));
    initial forever #5 CLOCK = ~CLOCK;
    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task automatic drive(input logic [7:0] c);
        ctl = c;
        tick(1);
        ctl = 0;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        tick(16);
        RST_N = 1;
        tick(1);
        chk({READY, ERROR, CSR_RDATA}, 18'h20080);
        for (i = 0; i < 14; i++) begin
            {CSR_WDATA[15:8], pins} = rows[i][30:18];
            drive(rows[i][38:31]);
            // eight cycles outlast sync stages and register delay
            tick(7);
            chk({READY, ERROR, CSR_RDATA}, rows[i][17:0]);
        end
        drive(8'h20);
        REPLY_WAIT = 1;
        tick(15);
        chk(CSR_RDATA[14], 0);
        for (i = 0; i < 30 && IRQ !== 1'b1; i++)
            tick(1);
        chk(IRQ, 1);
        REPLY_WAIT = 0;
        tick(3);
        chk({READY, ERROR, CSR_RDATA}, 18'h3c0c0);
        RST_N = 0;
        tick(1);
        chk({READY, ERROR, CSR_RDATA}, 18'h20000);
        RST_N = 1;
        tick(1);
        chk({READY, ERROR, CSR_RDATA}, 18'h20080);
        end_sim;
    end
endmodule // tb_top
